// ---- src/nvseq_top.sv ----
// Data EEPROM access sequencer: APB registers, 512 x 8 array, read,
// page erase and byte write sequencing with cycle timers.
// Assumes one clock, APB master on pclk, no wait from the array itself.
//
// Functional notes
// - Mode low byte read, high page read
// - Read start needs read_allow already set
// - Read end loads data, clears read_go
// - Data port holds until next operation
// - Page read: load, step address, clear
// - Each read_go set fetches next byte
// - Page read covers sixteen bytes
// - Step low nibble only, page bits fixed
// - Low nibble stops at 0fh
// - Erase only in page mode, tagged bytes only
// - Tags cleared at reset, wipe_allow fall
// - Data write tags address, steps nibble
// - Erase needs allow then go, consecutive
// - Timed erase, clear go then allow
// - Erased bytes read zero
// - End clears go, raises done flag
// - Byte write stores data at address
// - program_go ignored without program_allow
// - Write needs allow then go, consecutive
// - Timed write, clear go then allow
// - Target byte erased before programming
// - Cycle time from cycle_time_select
// - Done flag sticky until software clears
module nvseq_top
    import nvseq_pkg::*;
#(
    parameter int unsigned ERASE_FAST = ERASE_FAST_CYC, // Shorten for simulation
    parameter int unsigned ERASE_SLOW = ERASE_SLOW_CYC,
    parameter int unsigned WRITE_FAST = WRITE_FAST_CYC,
    parameter int unsigned WRITE_SLOW = WRITE_SLOW_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             nv_done_flag
);

    // Storage lives in sixteen byte columns, one per page offset, each held
    // inside its own generate branch below. One writer per column keeps
    // every process the sole driver of its cells. The cells carry no reset:
    // their contents survive a reset as real non-volatile cells would.
    logic [7:0]        col_rd [0:15];   // Column bytes of the current page

    // Software visible registers
    logic [7:0]        addr_low_q;      // Low address byte
    logic              addr_high_q;     // Address bit 8
    logic [7:0]        data_q;          // Data port
    nvseq_ctrl_s       ctrl_q;          // Control register
    logic              done_q;          // Sticky done flag
    logic [15:0]       tags_q;          // Page erase buffer
    logic              arm_wipe_q;      // Last transfer raised wipe_allow
    logic              arm_prog_q;      // Last transfer raised program_allow
    nvseq_state_e      state_q;         // Sequencer state
    logic [TMR_W-1:0]  tmr_q;           // Cycle timer
    logic [1:0]        rd_cnt_q;        // Read latency counter
    logic [31:0]       prdata_q;        // Registered read data
    logic              pready_q;        // Registered ready, access cycle only
    logic              pslverr_q;       // Registered error answer
    logic [TMR_W-1:0]  pg_hold_q;       // Load value of the running write
    nvseq_ctrl_s       ctrl_next;       // Next control register value

    // Bus phase decode. The answer is prepared in the setup cycle, so a transfer with
    // clk_en high at its setup edge has zero wait states and its access cycle completes.
    wire        setup_ph = psel & ~penable;
    wire        acc_done = psel & penable & pready_q;
    wire        wr_done  = acc_done & pwrite;
    wire        sel_alo  = paddr == OFF_ADDR_LOW;
    wire        sel_ahi  = paddr == OFF_ADDR_HIGH;
    wire        sel_dat  = paddr == OFF_DATA;
    wire        sel_ctl  = paddr == OFF_CONTROL;
    wire        sel_sts  = paddr == OFF_STATUS;
    wire        mapped   = sel_alo | sel_ahi | sel_dat | sel_ctl | sel_sts;

    // Write strobes per register
    wire        wr_alo   = wr_done & sel_alo;
    wire        wr_ahi   = wr_done & sel_ahi;
    wire        wr_dat   = wr_done & sel_dat;
    wire        wr_ctl   = wr_done & sel_ctl;
    wire        wr_sts   = wr_done & sel_sts;
    nvseq_ctrl_s wctl;
    assign wctl = nvseq_ctrl_s'(pwdata[7:0]);

    // Current address split into page and byte
    wire [8:0]  cur_addr = {addr_high_q, addr_low_q};
    wire [4:0]  page     = cur_addr[8:4]; // Page number, never stepped by hardware
    wire [3:0]  nib      = addr_low_q[3:0];
    wire [3:0]  nib_next = (nib == NIBBLE_END) ? nib : nib + 4'h1;
    wire        idle     = state_q == S_IDLE;

    // Start conditions. A start is only looked at while idle: a go bit that
    // arrives during a running cycle is dropped, not queued, so software
    // must poll for the end before it starts the next operation.
    wire start_rd = wr_ctl & idle & wctl.read_go & ctrl_q.read_allow;
    wire start_er = wr_ctl & idle & wctl.wipe_go & ctrl_q.wipe_allow
                    & arm_wipe_q & wctl.page_mode;
    wire start_pg = wr_ctl & idle & wctl.program_go & ctrl_q.program_allow
                    & arm_prog_q & ~wctl.page_mode;

    // Timer reload values picked by cycle_time_select. The select bit of the
    // go write itself counts, since that write may still change the field.
    // The count runs on pclk; gating pclk with clk_en stretches the cycle.
    wire [TMR_W-1:0] er_load = wctl.cycle_time_select ? TMR_W'(ERASE_SLOW)
                                                      : TMR_W'(ERASE_FAST);
    wire [TMR_W-1:0] pg_load = wctl.cycle_time_select ? TMR_W'(WRITE_SLOW)
                                                      : TMR_W'(WRITE_FAST);
    wire        tmr_end  = tmr_q == TMR_W'(1);
    wire        rd_end   = state_q == S_READ && rd_cnt_q == 2'h1;
    wire        er_end   = state_q == S_ERASE && tmr_end;
    wire        pg_end   = state_q == S_PROG && tmr_end;
    wire        cyc_end  = er_end | pg_end;

    // Page tagging on data port writes in page mode; the written byte itself
    // is a dummy and only marks the current offset for the next erase
    wire        tag_wr   = wr_dat & ctrl_q.page_mode & idle;

    // wipe_allow falling edge clears the buffer; a rise leaves it alone, so
    // tags written before arming survive into the erase
    wire        wipe_fall = ctrl_q.wipe_allow & ~ctrl_next.wipe_allow;

    // Read mux for the setup phase
    logic [31:0] rd_mux;
    assign rd_mux = sel_alo ? {24'h0, addr_low_q} :
                    sel_ahi ? {31'h0, addr_high_q} :
                    sel_dat ? {24'h0, data_q} :
                    sel_ctl ? {24'h0, ctrl_q} :
                    sel_sts ? {30'h0, ~idle, done_q} : 32'h0;

    // Next control value, software fields then hardware clears. Software
    // never writes a go bit itself: only an accepted start raises it, so a
    // refused start leaves no stale go bit behind.
    always_comb begin
        ctrl_next = ctrl_q;
        if (wr_ctl) begin
            // Go bits are never written directly; starts set them
            ctrl_next.cycle_time_select = wctl.cycle_time_select;
            ctrl_next.page_mode         = wctl.page_mode;
            ctrl_next.read_allow        = wctl.read_allow;
            ctrl_next.wipe_allow        = wctl.wipe_allow;
            ctrl_next.program_allow     = wctl.program_allow;
        end
        if (start_rd) begin
            ctrl_next.read_go = 1'b1;
        end
        if (start_er) begin
            ctrl_next.wipe_go = 1'b1;
        end
        if (start_pg) begin
            ctrl_next.program_go = 1'b1;
        end
        if (rd_end) begin
            ctrl_next.read_go = 1'b0;
        end
        if (er_end) begin
            ctrl_next.wipe_go = 1'b0;
        end
        if (pg_end) begin
            ctrl_next.program_go = 1'b0;
        end
        if (state_q == S_FINISH) begin
            // wipe_allow and program_allow drop one cycle after the go bits; read_allow is kept
            ctrl_next.wipe_allow    = 1'b0;
            ctrl_next.program_allow = 1'b0;
        end
    end

    // APB answer: data and ready prepared in the setup phase. Read data is
    // a snapshot taken one edge before the access edge; a status bit that
    // changes in between shows up on the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            pready_q  <= setup_ph;
            if (setup_ph) begin
                prdata_q  <= pwrite ? 32'h0 : rd_mux;
                pslverr_q <= ~mapped; // Unmapped answers with an error
            end else if (acc_done) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Control register and arming of the two-step starts. Arming lasts one
    // transfer only: any other access between the allow write and the go
    // write disarms, which guards against stray starts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= nvseq_ctrl_s'(RST_BYTE);
            arm_wipe_q <= 1'b0;
            arm_prog_q <= 1'b0;
        end else if (clk_en) begin
            ctrl_q <= ctrl_next;
            // Arm only for the very next transfer
            if (acc_done) begin
                arm_wipe_q <= wr_ctl & wctl.wipe_allow & ~ctrl_q.wipe_allow;
                arm_prog_q <= wr_ctl & wctl.program_allow
                              & ~ctrl_q.program_allow;
            end
        end
    end

    // Address pair: software writes, page stepping on reads and tags.
    // Only the low nibble steps; it stops at the page end and never wraps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low_q  <= RST_BYTE;
            addr_high_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_alo) begin
                addr_low_q <= pwdata[7:0];
            end else if ((rd_end & ctrl_q.page_mode) | tag_wr) begin
                addr_low_q[3:0] <= nib_next;
            end
            if (wr_ahi) begin
                addr_high_q <= pwdata[0];
            end
        end
    end

    // Data port: held until a read or a software write replaces it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= RST_BYTE;
        end else if (clk_en) begin
            if (rd_end) begin
                data_q <= col_rd[nib];
            end else if (wr_dat) begin
                data_q <= pwdata[7:0];
            end
        end
    end

    // Erase tags for the current page. Tags carry no page number: moving the
    // address to another page before the erase moves the tags with it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tags_q <= RST_TAGS;
        end else if (clk_en) begin
            if (wipe_fall) begin
                tags_q <= RST_TAGS;
            end else if (tag_wr) begin
                tags_q[nib] <= 1'b1;
            end
        end
    end

    // Sequencer: read latency and timed erase and write cycles. Reads use
    // their own short counter, so the long cycle timer never delays them.
    // The finish state gives the one cycle between go and allow clearing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= S_IDLE;
            tmr_q    <= '0;
            rd_cnt_q <= 2'h0;
        end else if (clk_en) begin
            unique case (state_q)
                S_IDLE: begin
                    if (start_rd) begin
                        state_q  <= S_READ;
                        rd_cnt_q <= READ_CYC;
                    end else if (start_er) begin
                        state_q <= S_ERASE;
                        tmr_q   <= er_load;
                    end else if (start_pg) begin
                        state_q <= S_PROG;
                        tmr_q   <= pg_load;
                    end
                end
                S_READ: begin
                    // Fixed short latency, independent of the timer
                    rd_cnt_q <= rd_cnt_q - 2'h1;
                    if (rd_end) begin
                        state_q <= S_IDLE;
                    end
                end
                S_ERASE, S_PROG: begin
                    tmr_q <= tmr_q - TMR_W'(1);
                    if (tmr_end) begin
                        state_q <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // First cycle of a byte write: the moment to erase the target byte.
    // The load value is kept because the bus word that chose it is gone
    // by the time the write runs.
    wire        pg_first = state_q == S_PROG && tmr_q == pg_hold_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_hold_q <= '0;
        end else if (clk_en && start_pg) begin
            pg_hold_q <= pg_load;
        end
    end

    // One byte column per page offset. An erase clears every tagged column
    // of the addressed page at its end; a byte write clears its own column
    // first and stores the data port at its end. A write timer of a single
    // cycle would let the erase win, so the write timers must exceed one.
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_page
            logic [7:0] col_q [0:31];         // Byte g of every page
            wire        hit = nib == 4'(g);   // Current address is in this column

            // Column read for the current page
            assign col_rd[g] = col_q[page];

            // Column writes, no reset
            always_ff @(posedge pclk) begin
                if (clk_en) begin
                    if (er_end && tags_q[g]) begin
                        col_q[page] <= RST_BYTE;
                    end else if (pg_first && hit) begin
                        col_q[page] <= RST_BYTE;
                    end else if (pg_end && hit) begin
                        col_q[page] <= data_q;
                    end
                end
            end
        end
    endgenerate

    // Done flag: set wins over a software clear. A clear that meets the end
    // of a cycle is lost on purpose, so no completion can go unseen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (clk_en) begin
            if (cyc_end) begin
                done_q <= 1'b1;
            end else if (wr_sts && pwdata[ST_DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // Outputs straight from flops; no logic sits between flop and port
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign nv_done_flag = done_q;

endmodule

// ---- shared/nvseq_pkg.sv ----
// Shared constants and types for the data EEPROM access sequencer.
// Assumes a 250 MHz APB clock and a 512 x 8 storage array.
package nvseq_pkg;

    // Clock period in nanoseconds
    localparam int unsigned CLK_NS = 4;

    // Cycle times in nanoseconds; kept in nanoseconds so every literal fits 32 bits
    localparam int unsigned ERASE_FAST_NS = 3200000;
    localparam int unsigned ERASE_SLOW_NS = 3700000;
    localparam int unsigned WRITE_FAST_NS = 2200000;
    localparam int unsigned WRITE_SLOW_NS = 3000000;

    // Least times round up to whole cycles
    localparam int unsigned ERASE_FAST_CYC = (ERASE_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ERASE_SLOW_CYC = (ERASE_SLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WRITE_FAST_CYC = (WRITE_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WRITE_SLOW_CYC = (WRITE_SLOW_NS + CLK_NS - 1) / CLK_NS;

    // Read access latency in clock cycles
    localparam logic [1:0] READ_CYC = 2'h2;

    // Timer width, enough for the slowest cycle
    localparam int unsigned TMR_W = 20;

    // Register byte offsets
    localparam logic [11:0] OFF_ADDR_LOW  = 12'h000;
    localparam logic [11:0] OFF_ADDR_HIGH = 12'h004;
    localparam logic [11:0] OFF_DATA      = 12'h008;
    localparam logic [11:0] OFF_CONTROL   = 12'h00c;
    localparam logic [11:0] OFF_STATUS    = 12'h010;

    // Status field positions
    localparam int unsigned ST_DONE_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 1;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_TAGS = 16'h0000;
    localparam logic [3:0] NIBBLE_END = 4'hf;

    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic cycle_time_select;
        logic wipe_allow;
        logic wipe_go;
        logic page_mode;
        logic program_allow;
        logic program_go;
        logic read_allow;
        logic read_go;
    } nvseq_ctrl_s;

    // Sequencer states
    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_READ   = 5'b00010,
        S_ERASE  = 5'b00100,
        S_PROG   = 5'b01000,
        S_FINISH = 5'b10000
    } nvseq_state_e;

endpackage

// ---- verification/nvseq_props.sv ----
// Port checker for the data EEPROM access sequencer.
// Assumes it is bound to nvseq_top and sees only its ports.
module nvseq_props
    import nvseq_pkg::*;
#(
    parameter int unsigned ERASE_FAST = 20, // Handed on from the top
    parameter int unsigned ERASE_SLOW = 30,
    parameter int unsigned WRITE_FAST = 10,
    parameter int unsigned WRITE_SLOW = 15
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        nv_done_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // Software clear of the sticky done flag
    wire done_clr = psel && penable && pready && pwrite && paddr == OFF_STATUS && pwdata[0];
    // Mapped means aligned and at or below status
    wire mapped = paddr <= OFF_STATUS && paddr[1:0] == 2'h0;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_setup: assert property (psel && !penable && clk_en |=> pready)
        else $error("pready missing in access cycle");
    chk_ready_once: assert property (pready && clk_en |=> !pready)
        else $error("pready held past access cycle");
    chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_refused_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");
    chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_done_sticky: assert property (nv_done_flag && clk_en && !done_clr |=> nv_done_flag)
        else $error("done flag dropped without clear");
    chk_status_done: assert property (pready && !pwrite && paddr == OFF_STATUS && clk_en
        |-> prdata[0] == $past(nv_done_flag))
        else $error("status bit disagrees with done flag");
endmodule

bind nvseq_top nvseq_props #(
    .ERASE_FAST(ERASE_FAST),
    .ERASE_SLOW(ERASE_SLOW),
    .WRITE_FAST(WRITE_FAST),
    .WRITE_SLOW(WRITE_SLOW)
) props_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nv_done_flag(nv_done_flag));

// ---- verification/tb.sv ----
// Self-checking bench: APB register calls for read, erase and write.
// Assumes short cycle timers and the offsets of the shared package.
module tb
    import nvseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EF = 20; // Shortened cycle timers
    localparam int ES = 30;
    localparam int WF = 10;
    localparam int WS = 15;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en = 1'b1; // Held high: freezing is not exercised
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        nv_done_flag;
    logic [31:0] rd; // Last read data
    logic        err; // Last error response
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc_n = 0;
    int          t0;
    logic [7:0]  pg [3] = '{8'h00, 8'h00, 8'h3c}; // Two erased bytes, one kept

    nvseq_top #(.ERASE_FAST(EF), .ERASE_SLOW(ES), .WRITE_FAST(WF), .WRITE_SLOW(WS)) dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nv_done_flag(nv_done_flag));

    // Clock and cycle count
    always #2 pclk = ~pclk;
    always @(posedge pclk) cyc_n <= cyc_n + 1;

    // One APB transfer; idle edge first so no signal is set twice at once
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold until pready is seen high at a rising edge; take the answer there
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compare a value with its expectation
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rd);
    endtask

    // Poll control until the masked bits clear; the watchdog bounds it
    task automatic poll(input logic [7:0] m);
        do xfer(OFF_CONTROL, 1'b0, 32'h0); while ((rd[7:0] & m) !== 8'h00);
    endtask

    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog far beyond the expected few hundred cycles
    initial begin
        #40000;
        bad_count++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(12'(i * 4), 32'h0, "reset value");
        xfer(12'h014, 1'b1, 32'hff);
        chk("unmapped error", 32'h1, {31'h0, err});
        rchk(12'h014, 32'h0, "unmapped data");
        xfer(OFF_ADDR_HIGH, 1'b1, 32'hff);
        rchk(OFF_ADDR_HIGH, 32'h1, "addr high");
        $display("test registers done");
        // Byte writes at both cycle times
        for (int ts = 0; ts < 2; ts++) begin
            xfer(OFF_ADDR_LOW, 1'b1, ts ? 32'h27 : 32'h25);
            xfer(OFF_DATA, 1'b1, ts ? 32'h3c : 32'ha5);
            xfer(OFF_CONTROL, 1'b1, {24'h0, ts[0], 7'h08});
            xfer(OFF_CONTROL, 1'b1, {24'h0, ts[0], 7'h0c});
            t0 = cyc_n;
            rchk(OFF_STATUS, 32'h2, "busy during write");
            poll(8'h0c);
            t0 = cyc_n - t0 - (ts ? WS : WF);
            chk("write time", 32'h1, {31'h0, t0 >= 0 && t0 <= 6});
            rchk(OFF_STATUS, 32'h1, "done after write");
            chk("done pin set", 32'h1, {31'h0, nv_done_flag});
            xfer(OFF_STATUS, 1'b1, 32'h1);
            rchk(OFF_STATUS, 32'h0, "done cleared");
            chk("done pin clear", 32'h0, {31'h0, nv_done_flag});
        end
        xfer(OFF_CONTROL, 1'b1, 32'h04);
        rchk(OFF_CONTROL, 32'h0, "go without allow");
        xfer(OFF_CONTROL, 1'b1, 32'h08);
        xfer(OFF_DATA, 1'b0, 32'h0);
        xfer(OFF_CONTROL, 1'b1, 32'h0c);
        rchk(OFF_CONTROL, 32'h08, "split start");
        xfer(OFF_CONTROL, 1'b1, 32'h00);
        $display("test byte write done");
        // Byte read, then a read with its allow bit low
        xfer(OFF_ADDR_LOW, 1'b1, 32'h25);
        xfer(OFF_CONTROL, 1'b1, 32'h02);
        xfer(OFF_CONTROL, 1'b1, 32'h03);
        t0 = cyc_n;
        poll(8'h01);
        chk("read time", 32'h1, {31'h0, cyc_n - t0 <= 8});
        rchk(OFF_DATA, 32'ha5, "byte read");
        xfer(OFF_CONTROL, 1'b1, 32'h00);
        xfer(OFF_ADDR_LOW, 1'b1, 32'h27);
        xfer(OFF_CONTROL, 1'b1, 32'h01);
        rchk(OFF_CONTROL, 32'h0, "read without allow");
        rchk(OFF_DATA, 32'ha5, "data held");
        $display("test byte read done");
        // Tag two bytes and erase the page
        xfer(OFF_ADDR_LOW, 1'b1, 32'h25);
        xfer(OFF_CONTROL, 1'b1, 32'h10);
        xfer(OFF_DATA, 1'b1, 32'h77);
        xfer(OFF_DATA, 1'b1, 32'h77);
        rchk(OFF_ADDR_LOW, 32'h27, "tag step");
        xfer(OFF_CONTROL, 1'b1, 32'h50);
        xfer(OFF_CONTROL, 1'b1, 32'h70);
        t0 = cyc_n;
        poll(8'h60);
        t0 = cyc_n - t0 - EF;
        chk("erase time", 32'h1, {31'h0, t0 >= 0 && t0 <= 6});
        chk("control after erase", 32'h10, rd);
        rchk(OFF_STATUS, 32'h1, "done after erase");
        $display("test page erase done");
        // Page read across erased and kept bytes, then the page end
        xfer(OFF_ADDR_LOW, 1'b1, 32'h25);
        xfer(OFF_CONTROL, 1'b1, 32'h12);
        for (int i = 0; i < 5; i++) begin
            if (i == 3) xfer(OFF_ADDR_LOW, 1'b1, 32'h2e);
            xfer(OFF_CONTROL, 1'b1, 32'h13);
            poll(8'h01);
            if (i < 3) rchk(OFF_DATA, {24'h0, pg[i]}, "page data");
            rchk(OFF_ADDR_LOW, i < 3 ? 32'h26 + i : 32'h2f, "page step");
        end
        rchk(OFF_ADDR_HIGH, 32'h1, "page bits");
        $display("test page read done");
        final_report();
    end
endmodule
